/* File: hw/pirc_irq_reset.v */
`timescale 1ns/1ns
`include "pirc_defines.vh"
module pirc_irq_reset #(
  parameter P_ENERGY_CYC = `PIRC_T_ENERGY_MS * `PIRC_US_PER_MS * `PIRC_CLK_MHZ,
  parameter P_RST_CYC = `PIRC_T_RSTX_US * `PIRC_CLK_MHZ
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Reset pin, straps and configuration pins
  input wire i_hw_reset_in_n,
  input wire [1:0] i_strap,
  input wire [3:0] i_cfg_pin,
  // Register access
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [4:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  // Status from the transceiver core
  input wire i_an_complete,
  input wire i_remote_fault,
  input wire i_link_up,
  input wire i_par_det_fault,
  input wire i_page_rx,
  input wire i_an_past_detect,
  input wire [7:0] i_idle_err_cnt,
  input wire i_idle_err_ovf,
  input wire i_tx_ovf,
  input wire i_tx_unf,
  // Interrupt and register data
  output wire o_irq_n,
  output wire [15:0] o_reg_rdata,
  // Control toward the core
  output wire o_core_reset,
  output wire o_power_down,
  output wire o_an_restart,
  output wire [1:0] o_tx_fifo_depth,
  output wire o_energy_present,
  output wire [1:0] o_strap_lat,
  output wire [3:0] o_cfg_lat
);
  // Pin synchronisers
  reg [2:0] rst_pin_ff;
  reg hw_lvl_ff;
  reg [5:0] pin_s1_ff;
  reg [5:0] pin_s2_ff;
  reg [5:0] pin_s3_ff;
  reg rst_all_d_ff;
  reg [1:0] strap_lat_ff;
  reg [3:0] cfg_lat_ff;
  // Register state
  reg [15:0] flags_ff;
  reg [15:0] mask_ff;
  reg [1:0] depth_ff;
  reg pd_ff;
  reg sreset_busy_ff;
  reg rst_ext_ff;
  reg an_restart_ff;
  reg [4:0] st_prev_ff;
  reg ep_ff;
  reg ep_boot_ff;
  reg ep_drop_ff;
  reg irq_n_ff;
  reg [15:0] rdata_ff;
  reg core_reset_ff;
  // Combinational
  reg ep_present_nxt;
  reg [15:0] nxt_flags;
  reg [15:0] flag_set;
  reg [15:0] flag_clr;
  reg [15:0] rd_mux;
  wire rst_all;
  wire wr0;
  wire rd1;
  wire rd6;
  wire rd10;
  wire rd29;
  wire [4:0] st_now;
  wire [4:0] st_rise;
  wire [4:0] st_fall;
  wire energy_found;
  wire ep_fall;
  wire energy_lost_hit;
  wire energy_drop_hit;
  wire rst_ext_hit;
  wire sreset_go;
  wire pd_exit;

  // Reset pin: three stages, level changes when stages two and three agree
  always @(posedge i_clk)
  begin
    // Strap stages run through reset, so release sees real levels
    pin_s1_ff <= {i_strap, i_cfg_pin};
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
    if (i_srst)
    begin
      rst_pin_ff <= 3'h7;
      hw_lvl_ff <= 1'b1;
    end
    else
    begin
      rst_pin_ff <= {rst_pin_ff[1:0], i_hw_reset_in_n};
      if (rst_pin_ff[1] == rst_pin_ff[2])
        hw_lvl_ff <= rst_pin_ff[2];
    end
  end

  assign rst_all = i_srst | ~hw_lvl_ff;

  // only the release edge samples them
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rst_all_d_ff <= 1'b1;
      strap_lat_ff <= 2'h0;
      cfg_lat_ff <= 4'h0;
    end
    else
    begin
      rst_all_d_ff <= rst_all;
      if (rst_all_d_ff && !rst_all)
      begin
        strap_lat_ff <= pin_s3_ff[5:4];
        cfg_lat_ff <= pin_s3_ff[3:0];
      end
    end
  end

  // Access decode
  assign wr0 = i_reg_wr && (i_reg_addr == `PIRC_R_BCTRL);
  assign rd1 = i_reg_rd && (i_reg_addr == `PIRC_R_BSTAT);
  assign rd6 = i_reg_rd && (i_reg_addr == `PIRC_R_ANEXP);
  assign rd10 = i_reg_rd && (i_reg_addr == `PIRC_R_IDLE);
  assign rd29 = i_reg_rd && (i_reg_addr == `PIRC_R_FLAGS);
  // write of one starts soft reset
  assign sreset_go = wr0 && i_reg_wdata[`PIRC_B_SOFT_RESET];
  assign pd_exit = wr0 && pd_ff && !i_reg_wdata[`PIRC_B_POWER_DOWN];
  // Status edges: an complete, remote fault, link, parallel fault, page
  assign st_now = {i_an_complete, i_remote_fault, i_link_up, i_par_det_fault, i_page_rx};
  assign st_rise = st_now & ~st_prev_ff;
  assign st_fall = ~st_now & st_prev_ff;
  // valid link or negotiation beyond ability detect
  assign energy_found = i_link_up | i_an_past_detect;
  assign ep_fall = ep_ff && !ep_present_nxt;
  // loss measured from link drop or return to ability detect
  pirc_timer #(
    .P_CYC(P_ENERGY_CYC)
  ) u_energy_lost (
    .i_clk(i_clk),
    .i_srst(rst_all),
    .i_run(ep_ff && !ep_drop_ff && !energy_found),
    .o_hit(energy_lost_hit)
  );

  // bit clears a further 256 ms after the flag
  pirc_timer #(
    .P_CYC(P_ENERGY_CYC)
  ) u_energy_drop (
    .i_clk(i_clk),
    .i_srst(rst_all),
    .i_run(ep_drop_ff && !energy_found),
    .o_hit(energy_drop_hit)
  );

  pirc_timer #(
    .P_CYC(P_RST_CYC)
  ) u_rst_ext (
    .i_clk(i_clk),
    .i_srst(rst_all),
    .i_run(rst_ext_ff),
    .o_hit(rst_ext_hit)
  );

  // Next energy-present level, also used for the falling-edge clear
  always @*
  begin
    ep_present_nxt = ep_ff;
    if (!ep_ff && energy_found)
      ep_present_nxt = 1'b1;
    else if (ep_boot_ff && energy_lost_hit)
      ep_present_nxt = 1'b0;
    else if (energy_drop_hit)
      ep_present_nxt = 1'b0;
  end

  // Flag set and clear terms; set always beats clear
  always @*
  begin
    flag_set = 16'h0000;
    flag_clr = 16'h0000;
    flag_set[`PIRC_F_TXOVF] = i_tx_ovf;
    flag_clr[`PIRC_F_TXOVF] = ~i_tx_ovf;
    flag_set[`PIRC_F_TXUNF] = i_tx_unf;
    flag_clr[`PIRC_F_TXUNF] = ~i_tx_unf;
    flag_set[`PIRC_F_IDLE] = i_idle_err_ovf;
    flag_clr[`PIRC_F_IDLE] = rd10;
    flag_set[`PIRC_F_ENERGY] = (!ep_ff && energy_found) || (energy_lost_hit && !ep_boot_ff);
    flag_clr[`PIRC_F_ENERGY] = ep_fall | rd29;
    flag_set[`PIRC_F_ANCMP] = st_rise[4];
    flag_clr[`PIRC_F_ANCMP] = st_fall[4] | rd29;
    flag_set[`PIRC_F_RFAULT] = st_rise[3];
    flag_clr[`PIRC_F_RFAULT] = st_fall[3] | rd1 | rd29;
    flag_set[`PIRC_F_LINKDN] = st_fall[2];
    flag_clr[`PIRC_F_LINKDN] = rd1 | rd29;
    flag_set[`PIRC_F_PDF] = st_rise[1];
    flag_clr[`PIRC_F_PDF] = st_fall[1] | rd6 | rd29 | an_restart_ff | st_fall[2];
    flag_set[`PIRC_F_PGRX] = st_rise[0];
    flag_clr[`PIRC_F_PGRX] = st_fall[0] | rd6 | rd29 | an_restart_ff | st_fall[2];
    nxt_flags = ((flags_ff & ~flag_clr) | flag_set) & `PIRC_FLAG_VALID;
  end

  // Read data
  always @*
  begin
    rd_mux = 16'h0000;
    case (i_reg_addr)
      `PIRC_R_BCTRL:
      begin
        rd_mux[`PIRC_B_SOFT_RESET] = sreset_busy_ff;
        rd_mux[`PIRC_B_POWER_DOWN] = pd_ff;
      end
      `PIRC_R_BSTAT:
      begin
        rd_mux[`PIRC_B_AN_CMP] = i_an_complete;
        rd_mux[`PIRC_B_RFAULT] = i_remote_fault;
        rd_mux[`PIRC_B_LINK] = i_link_up;
      end
      `PIRC_R_ANEXP:
      begin
        rd_mux[`PIRC_B_PDF] = i_par_det_fault;
        rd_mux[`PIRC_B_PGRX] = i_page_rx;
      end
      `PIRC_R_IDLE: rd_mux = {8'h00, i_idle_err_cnt};
      `PIRC_R_MODE: rd_mux[`PIRC_B_ENERGY] = ep_ff;
      `PIRC_R_EXTMODE: rd_mux[`PIRC_B_DEPTH_HI:`PIRC_B_DEPTH_LO] = depth_ff;
      `PIRC_R_FLAGS: rd_mux = flags_ff;
      `PIRC_R_MASK: rd_mux = mask_ff;
      default: rd_mux = `PIRC_RD_UNMAPPED;
    endcase
  end

  // Register file and reset sequencing
  always @(posedge i_clk)
  begin
    if (rst_all)
    begin
      flags_ff <= 16'h0000;
      // mask clear after pin or power-on reset
      mask_ff <= 16'h0000;
      depth_ff <= `PIRC_DEPTH_RST;
      pd_ff <= 1'b0;
      sreset_busy_ff <= 1'b0;
      rst_ext_ff <= 1'b0;
      an_restart_ff <= 1'b0;
      st_prev_ff <= 5'h00;
      // energy bit reads one after reset
      ep_ff <= 1'b1;
      ep_boot_ff <= 1'b1;
      ep_drop_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      irq_n_ff <= 1'b1;
      core_reset_ff <= 1'b1;
    end
    else
    begin
      st_prev_ff <= st_now;
      flags_ff <= nxt_flags;
      an_restart_ff <= wr0 && i_reg_wdata[`PIRC_B_AN_RESTART];
      if (i_reg_rd)
        rdata_ff <= rd_mux;
      // boot window ends on energy or timeout
      ep_ff <= ep_present_nxt;
      if (energy_found || energy_lost_hit)
        ep_boot_ff <= 1'b0;
      if (energy_lost_hit && !ep_boot_ff)
        ep_drop_ff <= 1'b1;
      else if (energy_drop_hit || energy_found)
        ep_drop_ff <= 1'b0;
      // software enables sources, reserved bits held zero
      if (i_reg_wr && i_reg_addr == `PIRC_R_MASK)
        mask_ff <= i_reg_wdata & `PIRC_FLAG_VALID;
      if (i_reg_wr && i_reg_addr == `PIRC_R_EXTMODE)
        depth_ff <= i_reg_wdata[`PIRC_B_DEPTH_HI:`PIRC_B_DEPTH_LO];
      if (wr0)
        pd_ff <= i_reg_wdata[`PIRC_B_POWER_DOWN];
      if (pd_exit)
        rst_ext_ff <= 1'b1;
      if (sreset_go)
      begin
        sreset_busy_ff <= 1'b1;
        rst_ext_ff <= 1'b1;
        // depth field exempt, logic state cleared
        flags_ff <= 16'h0000;
        mask_ff <= 16'h0000;
        pd_ff <= 1'b0;
      end
      else if (rst_ext_hit)
      begin
        sreset_busy_ff <= 1'b0;
        rst_ext_ff <= 1'b0;
      end
      // pin low while enabled flag pending
      irq_n_ff <= ~|(nxt_flags & mask_ff);
      core_reset_ff <= pd_ff | rst_ext_ff;
    end
  end

  assign o_irq_n = irq_n_ff;
  assign o_reg_rdata = rdata_ff;
  assign o_core_reset = core_reset_ff;
  assign o_power_down = pd_ff;
  assign o_an_restart = an_restart_ff;
  assign o_tx_fifo_depth = depth_ff;
  assign o_energy_present = ep_ff;
  assign o_strap_lat = strap_lat_ff;
  assign o_cfg_lat = cfg_lat_ff;
endmodule // pirc_irq_reset

/* File: hw/pirc_defines.vh */
// Behaviour
// - Interrupt pin low while enabled event pending
// - Mask register 30 gates flags in 29
// - Release pin when no enabled flag remains
// - Pin, power-on and soft reset clear whole mask register
// - Transmit buffer flags follow overflow/underflow condition
// - Negotiation-complete flag: rising set, falling/read clear
// - Remote fault flag: clears on falling, reads
// - Parallel fault, page flags: many clear causes
// - Energy bit starts 1, clears without energy
// - Energy found: set bit and energy flag
// - Energy lost: flag, bit clears 256 ms later
// - Energy flag fires 256 ms after loss
// - Two-bit depth field sets transmit buffer depth
// - Reset pin clears registers, relatches straps
// - Soft reset bit self-clears after 256 us
// - Soft reset spares exempt register bits
// - Soft reset never resamples straps or pins
// - Power-down exit resets without clearing registers
// - Power-down reset extended by 256 us
// - Clearing power-down bit ends general power-down
`ifndef PIRC_DEFINES_VH
`define PIRC_DEFINES_VH

`define PIRC_CLK_MHZ 100
`define PIRC_T_ENERGY_MS 256
`define PIRC_T_RSTX_US 256
`define PIRC_US_PER_MS 1000

// Register indices
`define PIRC_R_BCTRL 5'h00
`define PIRC_R_BSTAT 5'h01
`define PIRC_R_ANEXP 5'h06
`define PIRC_R_IDLE 5'h0a
`define PIRC_R_MODE 5'h11
`define PIRC_R_EXTMODE 5'h13
`define PIRC_R_FLAGS 5'h1d
`define PIRC_R_MASK 5'h1e
`define PIRC_RD_UNMAPPED 16'hffff

// Control, status, expansion and mode register bits
`define PIRC_B_SOFT_RESET 15
`define PIRC_B_POWER_DOWN 11
`define PIRC_B_AN_RESTART 9
`define PIRC_B_AN_CMP 5
`define PIRC_B_RFAULT 4
`define PIRC_B_LINK 2
`define PIRC_B_PDF 4
`define PIRC_B_PGRX 1
`define PIRC_B_ENERGY 1
`define PIRC_B_DEPTH_HI 10
`define PIRC_B_DEPTH_LO 9

// Flag positions in registers 29 and 30
`define PIRC_F_TXOVF 10
`define PIRC_F_TXUNF 9
`define PIRC_F_IDLE 8
`define PIRC_F_ENERGY 7
`define PIRC_F_ANCMP 6
`define PIRC_F_RFAULT 5
`define PIRC_F_LINKDN 4
`define PIRC_F_PDF 2
`define PIRC_F_PGRX 1
`define PIRC_FLAG_VALID 16'h07f6

`define PIRC_DEPTH_RST 2'h0
`define PIRC_TMR_W 26

`endif

/* File: hw/pirc_timer.v */
`timescale 1ns/1ns
`include "pirc_defines.vh"
module pirc_timer #(
  parameter P_CYC = `PIRC_T_RSTX_US * `PIRC_CLK_MHZ
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Count while high, restart when low
  input wire i_run,
  // One-cycle pulse after P_CYC running cycles
  output wire o_hit
);
  localparam integer LIM_I = P_CYC - 1;
  localparam [`PIRC_TMR_W-1:0] LIM_M1 = LIM_I[`PIRC_TMR_W-1:0];
  reg [`PIRC_TMR_W-1:0] cnt_ff;
  reg done_ff;

  // Saturates so a long run gives a single pulse
  always @(posedge i_clk)
  begin
    if (i_srst || !i_run)
    begin
      cnt_ff <= {`PIRC_TMR_W{1'b0}};
      done_ff <= 1'b0;
    end
    else if (!done_ff)
    begin
      if (cnt_ff == LIM_M1)
        done_ff <= 1'b1;
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign o_hit = i_run && !done_ff && (cnt_ff == LIM_M1);
endmodule // pirc_timer

/* File: test/pirc_irq_props_properties.sv */
`timescale 1ns/1ns
module pirc_irq_props #(
  parameter P_ENERGY_CYC = 20,
  parameter P_RST_CYC = 8
) (
  // Watched inputs
  input wire i_clk,
  input wire i_srst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [4:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_link_up,
  input wire i_an_past_detect,
  // Watched outputs
  input wire o_irq_n,
  input wire [15:0] o_reg_rdata,
  input wire o_core_reset,
  input wire o_power_down,
  input wire [1:0] o_tx_fifo_depth,
  input wire o_energy_present,
  input wire [1:0] o_strap_lat
);
  localparam int LIM = P_RST_CYC + 6;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire wr0 = i_reg_wr && i_reg_addr == 5'h00;
  property p_unmapped;
    i_reg_rd && i_reg_addr == 5'h0b |=> o_reg_rdata == 16'hffff;
  endproperty
  property p_mask_rsv;
    i_reg_rd && i_reg_addr == 5'h1e |=> (o_reg_rdata & 16'hf809) == 16'h0000;
  endproperty
  property p_flag_rsv;
    i_reg_rd && i_reg_addr == 5'h1d |=> (o_reg_rdata & 16'hf809) == 16'h0000;
  endproperty
  property p_rst_state;
    $fell(i_srst) |-> o_irq_n && o_energy_present && !o_power_down;
  endproperty
  property p_soft_exempt;
    wr0 && i_reg_wdata[15] |=> ($stable(o_tx_fifo_depth) && $stable(o_strap_lat))[*4];
  endproperty
  property p_pd_exit;
    o_power_down && wr0 && !i_reg_wdata[11] |=> o_core_reset[*5];
  endproperty
  property p_pd_end;
    $fell(o_power_down) |-> ##[1:LIM] !o_core_reset;
  endproperty
  property p_energy_set;
    !o_energy_present && $rose(i_link_up) |-> ##[1:3] o_energy_present;
  endproperty
  property p_energy_fall;
    $fell(o_energy_present) |-> !i_link_up && !i_an_past_detect;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read wrong");
  a_mask_rsv: assert property (p_mask_rsv)
    else $error("reserved mask bit set");
  a_flag_rsv: assert property (p_flag_rsv)
    else $error("reserved flag bit set");
  a_rst_state: assert property (p_rst_state)
    else $error("bad state after reset");
  a_soft_exempt: assert property (p_soft_exempt)
    else $error("soft reset touched exempt bits");
  a_pd_exit: assert property (p_pd_exit)
    else $error("no reset on power-down exit");
  a_pd_end: assert property (p_pd_end)
    else $error("power-down reset too long");
  a_energy_set: assert property (p_energy_set)
    else $error("energy bit not set");
  a_energy_fall: assert property (p_energy_fall)
    else $error("energy bit fell with energy");
  c_pd_exit: cover property (o_power_down && wr0 && !i_reg_wdata[11]);
  c_energy_fall: cover property ($fell(o_energy_present));
  c_unmapped: cover property (i_reg_rd && i_reg_addr == 5'h0b);
endmodule // pirc_irq_props

bind pirc_irq_reset pirc_irq_props #(
  .P_ENERGY_CYC(P_ENERGY_CYC),
  .P_RST_CYC(P_RST_CYC)
) pirc_irq_props_inst (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .i_link_up(i_link_up),
  .i_an_past_detect(i_an_past_detect),
  .o_irq_n(o_irq_n),
  .o_reg_rdata(o_reg_rdata),
  .o_core_reset(o_core_reset),
  .o_power_down(o_power_down),
  .o_tx_fifo_depth(o_tx_fifo_depth),
  .o_energy_present(o_energy_present),
  .o_strap_lat(o_strap_lat)
);

/* File: test/pirc_mgmt_model.sv */
`timescale 1ns/1ns
module pirc_mgmt_model #(
  parameter P_LOW = 6
) (
  input wire i_clk,
  input wire i_go,
  output wire o_hw_reset_n
);
  int cnt = 0;
  // reset pin pulse
  // Long enough for the pin synchroniser to see
  always @(posedge i_clk)
  begin
    if (i_go)
      cnt <= P_LOW;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign o_hw_reset_n = (cnt == 0);
endmodule // pirc_mgmt_model

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
  localparam int P_E = 20;
  localparam int P_R = 8;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [4:0] i_reg_addr = 5'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [1:0] i_strap = 2'h2;
  logic i_an_complete = 1'b0, i_remote_fault = 1'b0, i_link_up = 1'b0;
  logic i_par_det_fault = 1'b0, i_page_rx = 1'b0, i_an_past_detect = 1'b1;
  logic i_tx_ovf = 1'b0, i_tx_unf = 1'b0, go = 1'b0;
  wire hw_rst_n, o_irq_n, o_core_reset, o_power_down, o_energy_present, o_an_restart;
  wire [15:0] o_reg_rdata;
  wire [1:0] o_tx_fifo_depth, o_strap_lat;
  wire [3:0] o_cfg_lat;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  always #5 i_clk = ~i_clk;
  pirc_mgmt_model pirc_mgmt_model_inst (.i_clk(i_clk), .i_go(go), .o_hw_reset_n(hw_rst_n));
  pirc_irq_reset #(.P_ENERGY_CYC(P_E), .P_RST_CYC(P_R)) pirc_irq_reset_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_hw_reset_in_n(hw_rst_n), .i_strap(i_strap),
    .i_cfg_pin(4'h5), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_an_complete(i_an_complete), .i_remote_fault(i_remote_fault),
    .i_link_up(i_link_up), .i_par_det_fault(i_par_det_fault), .i_page_rx(i_page_rx),
    .i_an_past_detect(i_an_past_detect), .i_idle_err_cnt(8'h00), .i_idle_err_ovf(1'b0),
    .i_tx_ovf(i_tx_ovf), .i_tx_unf(i_tx_unf), .o_irq_n(o_irq_n), .o_reg_rdata(o_reg_rdata),
    .o_core_reset(o_core_reset), .o_power_down(o_power_down), .o_an_restart(o_an_restart),
    .o_tx_fifo_depth(o_tx_fifo_depth), .o_energy_present(o_energy_present),
    .o_strap_lat(o_strap_lat), .o_cfg_lat(o_cfg_lat));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    tick(1);
    chk(o_reg_rdata & m, e);
  endtask
  task wait_low(input bit sel, output int c);
    c = 0;
    while ((sel ? o_energy_present : o_irq_n) !== 1'b0 && c < 100)
    begin
      @(posedge i_clk);
      #1;
      c++;
    end
    #1;
  endtask
  task report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    tick(2);
    chk(16'({o_strap_lat, o_cfg_lat}), 16'h25);
    rd(5'h1e, 16'h0000);
    rd(5'h0b, 16'hffff);
    wr(5'h1e, 16'hffff);
    rd(5'h1e, 16'h07f6);
    chk(16'(o_irq_n), 16'h1);
    @(posedge i_clk) i_an_complete <= 1'b1;
    tick(2);
    chk(16'(o_irq_n), 16'h0);
    rd(5'h1d, 16'h0040);
    chk(16'(o_irq_n), 16'h1);
    wr(5'h1e, 16'h0000);
    @(posedge i_clk) i_remote_fault <= 1'b1;
    tick(2);
    chk(16'(o_irq_n), 16'h1);
    rd(5'h1d, 16'h0020);
    @(posedge i_clk) i_remote_fault <= 1'b0;
    @(posedge i_clk) i_remote_fault <= 1'b1;
    tick(2);
    rd(5'h01, 16'h0010, 16'h0010);
    rd(5'h1d, 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      wr(5'h1e, 16'h0400 >> k);
      @(posedge i_clk) {i_tx_ovf, i_tx_unf} <= 2'b10 >> k;
      tick(2);
      rd(5'h1d, 16'h0400 >> k);
      chk(16'(o_irq_n), 16'h0);
      @(posedge i_clk) {i_tx_ovf, i_tx_unf} <= 2'b00;
      tick(2);
      chk(16'(o_irq_n), 16'h1);
    end
    wr(5'h1e, 16'h0006);
    @(posedge i_clk) i_page_rx <= 1'b1;
    tick(2);
    chk(16'(o_irq_n), 16'h0);
    rd(5'h06, 16'h0002, 16'h0002);
    rd(5'h1d, 16'h0000);
    @(posedge i_clk) i_par_det_fault <= 1'b1;
    tick(2);
    wr(5'h00, 16'h0200);
    chk(16'(o_an_restart), 16'h1);
    rd(5'h1d, 16'h0000);
    wr(5'h13, 16'h0400);
    chk(16'(o_tx_fifo_depth), 16'h2);
    wr(5'h1e, 16'h0040);
    @(posedge i_clk) i_strap <= 2'h1;
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h8000, 16'h8000);
    tick(P_R + 4);
    rd(5'h00, 16'h0000, 16'h8000);
    rd(5'h1e, 16'h0000);
    chk(16'({o_tx_fifo_depth, o_strap_lat}), 16'ha);
    wr(5'h1e, 16'h0002);
    wr(5'h00, 16'h0800);
    tick(1);
    chk(16'({o_power_down, o_core_reset}), 16'h3);
    wr(5'h00, 16'h0000);
    tick(2);
    chk(16'(o_core_reset), 16'h1);
    tick(P_R + 4);
    chk(16'(o_core_reset), 16'h0);
    rd(5'h1e, 16'h0002);
    wr(5'h1e, 16'h0080);
    @(posedge i_clk) i_an_past_detect <= 1'b0;
    wait_low(1'b0, n);
    chk(16'(n), 16'(P_E));
    chk(16'({o_energy_present, o_irq_n}), 16'h2);
    rd(5'h1d, 16'h0080);
    // Handler drops the energy mask
    wr(5'h1e, 16'h0000);
    wait_low(1'b1, n);
    chk(16'({o_energy_present, n >= P_E - 8}), 16'h1);
    wr(5'h1e, 16'h0080);
    @(posedge i_clk) i_link_up <= 1'b1;
    tick(3);
    chk(16'({o_energy_present, o_irq_n}), 16'h2);
    @(posedge i_clk) go <= 1'b1;
    @(posedge i_clk) go <= 1'b0;
    tick(16);
    rd(5'h1e, 16'h0000);
    chk(16'({o_tx_fifo_depth, o_strap_lat}), 16'h1);
    report_and_stop;
  end
endmodule // tb
